// ==== core/bcf_top.sv ====
// bidirectional clocked queue pair with mailboxes, ports a and b
// assumes both ports synchronous to SYS_CLK_I; data pins split in/out/enable
//
// Overview of operation
// RQ1 - partner holds reset at least four edges
// RQ2 - reset accepted at any time
// RQ3 - reset clears pointers, sets flag levels
// RQ4 - reset forces mailbox flags high
// RQ5 - full flags rise two edges after reset
// RQ6 - partner resets device before writing data
// RQ7 - offset selects captured at reset release
// RQ8 - offset decode: 16, 12, 8, 4
// RQ9 - port a data released when deselected
// RQ10 - port a drives when selected and reading
// RQ11 - port a writes a-to-b queue
// RQ12 - port a reads b-to-a queue
// RQ13 - port b data drive like port a
// RQ14 - port b writes b-to-a queue
// RQ15 - port b reads a-to-b queue
// RQ16 - each mailbox flag edge from one port
// RQ17 - mail write seen at far outputs
// RQ18 - mailbox select steers outputs combinationally
// RQ19 - mailbox write, mailbox read sets flag
// RQ20 - reads ignored while empty
// RQ21 - writes ignored while full
// RQ22 - almost empty low at offset or less
// RQ23 - two 64 by 36 queues
`timescale 1ns/1ps
`include "bcf_params.svh"

module bcf_top (
	// clock and reset
	input wire logic SYS_CLK_I,
	input wire logic NRST_I,
	// offset selection
	input wire logic OFFSET_SELECT_HIGH_I,
	input wire logic OFFSET_SELECT_LOW_I,
	// port a control
	input wire logic PORT_A_SELECT_N_I,
	input wire logic PORT_A_WRITE_NOT_READ_I,
	input wire logic PORT_A_ENABLE_I,
	input wire logic PORT_A_MAILBOX_SELECT_I,
	// port a data
	input wire bcf_pkg::bcf_word_t PORT_A_DATA_I,
	output logic [35:0] PORT_A_DATA_O,
	output logic PORT_A_DATA_OE_O,
	// port a flags
	output logic PORT_A_FULL_N_O,
	output logic PORT_A_EMPTY_N_O,
	output logic PORT_A_ALMOST_FULL_N_O,
	output logic PORT_A_ALMOST_EMPTY_N_O,
	// port b control
	input wire logic PORT_B_SELECT_N_I,
	input wire logic PORT_B_WRITE_NOT_READ_I,
	input wire logic PORT_B_ENABLE_I,
	input wire logic PORT_B_MAILBOX_SELECT_I,
	// port b data
	input wire bcf_pkg::bcf_word_t PORT_B_DATA_I,
	output logic [35:0] PORT_B_DATA_O,
	output logic PORT_B_DATA_OE_O,
	// port b flags
	output logic PORT_B_FULL_N_O,
	output logic PORT_B_EMPTY_N_O,
	output logic PORT_B_ALMOST_FULL_N_O,
	output logic PORT_B_ALMOST_EMPTY_N_O,
	// mailbox flags
	output logic MAILBOX_AB_FULL_N_O,
	output logic MAILBOX_BA_FULL_N_O
);
	import bcf_pkg::*;

	function automatic bcf_count_t offset_decode(input logic hi, input logic lo);
		bcf_count_t v;
		v = `BCF_OFS_LL;
		if (hi && lo) begin
			v = `BCF_OFS_HH;
		end else if (hi) begin
			v = `BCF_OFS_HL;
		end else if (lo) begin
			v = `BCF_OFS_LH;
		end
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// per-port views, index 0 = port a, 1 = port b
	logic sel_n [0:1];
	logic wnr [0:1];
	logic en [0:1];
	logic mbs [0:1];
	bcf_word_t din [0:1];
	logic q_wr [0:1];
	logic q_rd [0:1];
	logic mb_wr [0:1];
	logic mb_rd [0:1];
	bcf_if qi [0:1] ();

	assign sel_n[0] = PORT_A_SELECT_N_I;
	assign sel_n[1] = PORT_B_SELECT_N_I;
	assign wnr[0] = PORT_A_WRITE_NOT_READ_I;
	assign wnr[1] = PORT_B_WRITE_NOT_READ_I;
	assign en[0] = PORT_A_ENABLE_I;
	assign en[1] = PORT_B_ENABLE_I;
	assign mbs[0] = PORT_A_MAILBOX_SELECT_I;
	assign mbs[1] = PORT_B_MAILBOX_SELECT_I;
	assign din[0] = PORT_A_DATA_I;
	assign din[1] = PORT_B_DATA_I;

	////////////////////////////////////////////////////////////////////////
	// reset sequencer and offset capture
	bcf_rst_t rst_st_q, rst_st_d;
	bcf_count_t ofs_q, ofs_d;
	logic run;

	always_comb begin
		rst_st_d = rst_st_q;
		ofs_d = ofs_q;
		case (rst_st_q)
			BCF_HOLD: begin
				rst_st_d = BCF_WAIT;
				ofs_d = offset_decode(OFFSET_SELECT_HIGH_I, OFFSET_SELECT_LOW_I); // RQ7 RQ8
			end
			BCF_WAIT: rst_st_d = BCF_RUN; // RQ5
			default: rst_st_d = BCF_RUN;
		endcase
	end

	always_ff @(posedge SYS_CLK_I) begin
		if (!NRST_I) begin
			rst_st_q <= BCF_HOLD; // RQ2
			ofs_q <= `BCF_OFS_RST;
		end else begin
			rst_st_q <= rst_st_d;
			ofs_q <= ofs_d;
		end
	end
	assign run = rst_st_d == BCF_RUN;

	////////////////////////////////////////////////////////////////////////
	// queues: qi[0] carries a to b, qi[1] carries b to a
	logic full_n_q [0:1];
	logic full_n_d [0:1];
	logic empty_n_q [0:1];
	logic empty_n_d [0:1];
	logic af_n_q [0:1];
	logic af_n_d [0:1];
	logic ae_n_q [0:1];
	logic ae_n_d [0:1];
	bcf_word_t qout_q [0:1];
	bcf_word_t qout_d [0:1];
	bcf_word_t mbox_q [0:1];
	bcf_word_t mbox_d [0:1];
	logic mbf_n_q [0:1];
	logic mbf_n_d [0:1];

	for (genvar p = 0; p < 2; p++) begin : g_port
		bcf_queue u_queue ( // RQ23
			.clk_i(SYS_CLK_I),
			.rst_n_i(NRST_I),
			.q(qi[p])
		);
		assign q_wr[p] = !sel_n[p] && wnr[p] && en[p] && !mbs[p] && full_n_q[p]; // RQ11 RQ14 RQ21
		assign q_rd[p] = !sel_n[p] && !wnr[p] && en[p] && !mbs[p] && empty_n_q[p]; // RQ12 RQ15 RQ20
		assign mb_wr[p] = !sel_n[p] && wnr[p] && en[p] && mbs[p]; // RQ19
		assign mb_rd[p] = !sel_n[p] && !wnr[p] && en[p] && mbs[p];
		assign qi[p].wr_valid = q_wr[p];
		assign qi[p].wr_data = din[p];
		assign qi[1-p].rd_ready = q_rd[p];

		always_comb begin
			full_n_d[p] = run && (qi[p].level + 7'h01 < `BCF_DEPTH + 7'h01) &&
				!(qi[p].level == `BCF_DEPTH - 7'h01 && qi[p].wr_valid);
			af_n_d[p] = !run || (qi[p].level < `BCF_DEPTH - ofs_q);
			empty_n_d[p] = run && qi[1-p].rd_valid && !(q_rd[p] && qi[1-p].level == 7'h01);
			ae_n_d[p] = run && (qi[1-p].level > ofs_q); // RQ22
			qout_d[p] = (q_rd[p] && qi[1-p].rd_valid) ? qi[1-p].rd_data : qout_q[p];
			mbox_d[p] = mb_wr[p] ? din[p] : mbox_q[p];
			mbf_n_d[p] = mbf_n_q[p];
			if (mb_rd[1-p]) begin
				mbf_n_d[p] = 1'b1; // RQ19
			end
			if (mb_wr[p]) begin
				mbf_n_d[p] = 1'b0; // RQ16
			end
		end

		always_ff @(posedge SYS_CLK_I) begin
			if (!NRST_I) begin
				full_n_q[p] <= 1'b0; // RQ3
				empty_n_q[p] <= 1'b0;
				af_n_q[p] <= 1'b1;
				ae_n_q[p] <= 1'b0;
				qout_q[p] <= 36'h0;
				mbox_q[p] <= 36'h0;
				mbf_n_q[p] <= 1'b1; // RQ4
			end else begin
				full_n_q[p] <= full_n_d[p];
				empty_n_q[p] <= empty_n_d[p];
				af_n_q[p] <= af_n_d[p];
				ae_n_q[p] <= ae_n_d[p];
				qout_q[p] <= qout_d[p];
				mbox_q[p] <= mbox_d[p];
				mbf_n_q[p] <= mbf_n_d[p];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// pins: data steered by mailbox select without a clock
	assign PORT_A_DATA_O = PORT_A_MAILBOX_SELECT_I ? mbox_q[1] : qout_q[0]; // RQ17 RQ18
	assign PORT_B_DATA_O = PORT_B_MAILBOX_SELECT_I ? mbox_q[0] : qout_q[1]; // RQ17 RQ18
	assign PORT_A_DATA_OE_O = !PORT_A_SELECT_N_I && !PORT_A_WRITE_NOT_READ_I; // RQ9 RQ10
	assign PORT_B_DATA_OE_O = !PORT_B_SELECT_N_I && !PORT_B_WRITE_NOT_READ_I; // RQ13
	assign PORT_A_FULL_N_O = full_n_q[0];
	assign PORT_B_FULL_N_O = full_n_q[1];
	assign PORT_A_EMPTY_N_O = empty_n_q[0];
	assign PORT_B_EMPTY_N_O = empty_n_q[1];
	assign PORT_A_ALMOST_FULL_N_O = af_n_q[0];
	assign PORT_B_ALMOST_FULL_N_O = af_n_q[1];
	assign PORT_A_ALMOST_EMPTY_N_O = ae_n_q[0];
	assign PORT_B_ALMOST_EMPTY_N_O = ae_n_q[1];
	assign MAILBOX_AB_FULL_N_O = mbf_n_q[0];
	assign MAILBOX_BA_FULL_N_O = mbf_n_q[1];

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge SYS_CLK_I); endclocking

	a_reset_flags: assert property (!NRST_I |=> // RQ3 RQ4
		!PORT_A_FULL_N_O && !PORT_B_FULL_N_O && !PORT_A_EMPTY_N_O && !PORT_B_EMPTY_N_O &&
		!PORT_A_ALMOST_EMPTY_N_O && !PORT_B_ALMOST_EMPTY_N_O && PORT_A_ALMOST_FULL_N_O &&
		PORT_B_ALMOST_FULL_N_O && MAILBOX_AB_FULL_N_O && MAILBOX_BA_FULL_N_O)
		else $error("reset flag levels wrong");
	a_full_release: assert property (!NRST_I ##1 NRST_I [*2] |=> // RQ5
		PORT_A_FULL_N_O && PORT_B_FULL_N_O)
		else $error("full flags not up two edges after reset");
	a_full_early: assert property (!NRST_I ##1 NRST_I |=> // RQ5
		!PORT_A_FULL_N_O && !PORT_B_FULL_N_O)
		else $error("full flag rose too early");
	a_offset_load: assert property (disable iff (!NRST_I) $rose(NRST_I) |=> // RQ7 RQ8
		ofs_q == ($past(OFFSET_SELECT_HIGH_I) ?
		($past(OFFSET_SELECT_LOW_I) ? `BCF_OFS_HH : `BCF_OFS_HL) :
		($past(OFFSET_SELECT_LOW_I) ? `BCF_OFS_LH : `BCF_OFS_LL)))
		else $error("offset not loaded from selects");
	a_oe_drive: assert property ( // RQ9 RQ10
		PORT_A_DATA_OE_O == (!PORT_A_SELECT_N_I && !PORT_A_WRITE_NOT_READ_I))
		else $error("port a output enable wrong");
	a_write_full: assert property (disable iff (!NRST_I) !PORT_B_FULL_N_O |=> // RQ21
		qi[1].level <= $past(qi[1].level))
		else $error("write taken while full");
	a_read_empty: assert property (disable iff (!NRST_I) !PORT_B_EMPTY_N_O |=> // RQ20
		$stable(qout_q[1]))
		else $error("read taken while empty");
	a_mail_flag: assert property (disable iff (!NRST_I) mb_wr[0] |=> // RQ17
		!MAILBOX_AB_FULL_N_O &&
		(!PORT_B_MAILBOX_SELECT_I || PORT_B_DATA_O == $past(PORT_A_DATA_I)))
		else $error("mail write not flagged");
	a_mail_read: assert property (disable iff (!NRST_I) mb_rd[1] && !mb_wr[0] |=> // RQ19
		MAILBOX_AB_FULL_N_O)
		else $error("mail read did not clear flag");
	a_almost_empty: assert property (disable iff (!NRST_I) run && qi[0].level <= ofs_q |=> // RQ22
		!PORT_B_ALMOST_EMPTY_N_O)
		else $error("almost empty high at offset");

	c_write_a: cover property (disable iff (!NRST_I) q_wr[0]);
	c_read_b: cover property (disable iff (!NRST_I) q_rd[1]);
	c_full_b: cover property (disable iff (!NRST_I) !PORT_B_FULL_N_O && qi[1].level == `BCF_DEPTH);
	c_mail: cover property (disable iff (!NRST_I) mb_wr[0] ##[1:20] mb_rd[1]);
endmodule

// ==== core/bcf_params.svh ====
// constants of the bidirectional clocked queue pair
// assumes inclusion by bare name from the package and the modules
`ifndef BCF_PARAMS_SVH
`define BCF_PARAMS_SVH

`define BCF_WIDTH 36
`define BCF_DEPTH 7'd64
`define BCF_AW 6
`define BCF_CW 7
`define BCF_OFS_HH 7'd16
`define BCF_OFS_HL 7'd12
`define BCF_OFS_LH 7'd8
`define BCF_OFS_LL 7'd4
`define BCF_OFS_RST 7'd4
`define BCF_FULL_EDGES 2

`endif

// ==== core/bcf_pkg.sv ====
// types shared by the queue pair modules
// assumes bcf_params.svh on the include path
`include "bcf_params.svh"

package bcf_pkg;
	typedef logic [`BCF_WIDTH-1:0] bcf_word_t;
	typedef logic [`BCF_CW-1:0] bcf_count_t;
	typedef logic [`BCF_AW-1:0] bcf_ptr_t;
	// gray along hold -> wait -> run
	typedef enum logic [1:0] {
		BCF_HOLD = 2'h0,
		BCF_WAIT = 2'h1,
		BCF_RUN = 2'h3
	} bcf_rst_t;
endpackage

// ==== core/bcf_if.sv ====
// carrier between the top and one queue
// assumes one clock shared by both ends
`timescale 1ns/1ps

interface bcf_if;
	import bcf_pkg::*;
	logic wr_valid;
	logic wr_ready;
	bcf_word_t wr_data;
	logic rd_valid;
	logic rd_ready;
	bcf_word_t rd_data;
	bcf_count_t level;
	modport queue_side (input wr_valid, wr_data, rd_ready, output wr_ready, rd_valid, rd_data, level);
	modport user_side (output wr_valid, wr_data, rd_ready, input wr_ready, rd_valid, rd_data, level);
endinterface

// ==== core/bcf_queue.sv ====
// one 64 x 36 queue with a two-entry output buffer
// assumes synchronous active-low reset and one clock
`timescale 1ns/1ps
`include "bcf_params.svh"

module bcf_queue (
	input wire logic clk_i,
	input wire logic rst_n_i,
	bcf_if.queue_side q
);
	import bcf_pkg::*;

	bcf_word_t mem [0:63];
	bcf_ptr_t wr_ptr_q, wr_ptr_d, rd_ptr_q, rd_ptr_d;
	bcf_count_t mem_cnt_q, mem_cnt_d;
	bcf_word_t buf_q [0:1];
	bcf_word_t buf_d [0:1];
	logic [1:0] bcnt_q, bcnt_d;
	logic push, pop, fill;
	logic [1:0] left;
	bcf_count_t total;

	////////////////////////////////////////////////////////////////////////
	// status and handshakes
	assign total = mem_cnt_q + bcf_count_t'(bcnt_q);
	assign q.level = total;
	assign q.wr_ready = total < `BCF_DEPTH;
	assign q.rd_valid = bcnt_q != 2'h0;
	assign q.rd_data = buf_q[0];
	assign push = q.wr_valid && q.wr_ready;
	assign pop = q.rd_valid && q.rd_ready;

	////////////////////////////////////////////////////////////////////////
	// memory and buffer next state
	always_comb begin
		left = bcnt_q - {1'b0, pop};
		fill = (mem_cnt_q != 7'h00) && (left < 2'h2);
		wr_ptr_d = push ? wr_ptr_q + 6'h01 : wr_ptr_q;
		rd_ptr_d = fill ? rd_ptr_q + 6'h01 : rd_ptr_q;
		mem_cnt_d = mem_cnt_q + bcf_count_t'(push) - bcf_count_t'(fill);
		buf_d[0] = pop ? buf_q[1] : buf_q[0];
		buf_d[1] = buf_q[1];
		if (fill) begin
			buf_d[left[0]] = mem[rd_ptr_q];
		end
		bcnt_d = left + {1'b0, fill};
	end

	always_ff @(posedge clk_i) begin
		if (!rst_n_i) begin
			wr_ptr_q <= 6'h00;
			rd_ptr_q <= 6'h00;
			mem_cnt_q <= 7'h00;
			bcnt_q <= 2'h0;
			buf_q[0] <= 36'h0;
			buf_q[1] <= 36'h0;
		end else begin
			wr_ptr_q <= wr_ptr_d;
			rd_ptr_q <= rd_ptr_d;
			mem_cnt_q <= mem_cnt_d;
			bcnt_q <= bcnt_d;
			buf_q[0] <= buf_d[0];
			buf_q[1] <= buf_d[1];
		end
	end

	always_ff @(posedge clk_i) begin
		if (push) begin
			mem[wr_ptr_q] <= q.wr_data;
		end
	end

	a_level_bound: assert property (@(posedge clk_i) disable iff (!rst_n_i) // RQ23
		total <= `BCF_DEPTH) else $error("queue level above capacity");
endmodule

// ==== tb/bcf_port_model.sv ====
// bus master model for one port of the queue pair
// assumes calls start just after a falling clock edge
`timescale 1ns/1ps

module bcf_port_model (
	// clock
	input wire logic clk_i,
	// controls towards the device
	output logic sel_n_o,
	output logic wnr_o,
	output logic en_o,
	output logic mbs_o,
	output bcf_pkg::bcf_word_t data_o,
	// answer from the device
	input wire bcf_pkg::bcf_word_t data_i
);
	import bcf_pkg::*;
	bcf_word_t seen;
	initial begin
		sel_n_o = 1'b1;
		wnr_o = 1'b1;
		en_o = 1'b0;
		mbs_o = 1'b0;
		data_o = '0;
	end
	// data while deselected or reading is inverted so stale words never look valid
	task automatic drv(input logic s, w, e, m, input bcf_word_t d);
		sel_n_o = s;
		wnr_o = w;
		en_o = e;
		mbs_o = m;
		data_o = (s || !w) ? ~data_o : d;
	endtask
	// one transfer held through the rising edge, answer taken after it
	task automatic op(input logic w, m, input bcf_word_t d);
		drv(1'b0, w, 1'b1, m, d);
		@(negedge clk_i);
		seen = data_i;
	endtask
	task automatic idle(input int n);
		drv(1'b1, 1'b1, 1'b0, 1'b0, '0);
		repeat (n) @(negedge clk_i);
	endtask
endmodule

// ==== tb/bcf_top_bench.sv ====
// self-checking bench for the queue pair with two port masters
// assumes bcf_pkg and the port model compiled first
`timescale 1ns/1ps
`include "bcf_params.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fail_count++; \
	$display("[ERR] %s exp %h got %h", n, e, g); end end

module bcf_top_bench;
	import bcf_pkg::*;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic fs_hi = 1'b0;
	logic fs_lo = 1'b0;
	wire [3:0] ca;
	wire [3:0] cb;
	wire bcf_word_t da;
	wire bcf_word_t db;
	bcf_word_t qa, qb, w, last;
	logic fa, ea, afa, aea, oea, fb, eb, afb, aeb, oeb, m1, m2;
	int fail_count = 0;
	int comparisons = 0;
	int cyc = 0;
	logic [31:0] lfsr = 32'hd0b2;
	bcf_word_t ab_q[$];
	bcf_word_t ba_q[$];

	always #5 clk = ~clk;

	bcf_port_model pa (.clk_i(clk), .sel_n_o(ca[3]), .wnr_o(ca[2]), .en_o(ca[1]),
		.mbs_o(ca[0]), .data_o(da), .data_i(qa));
	bcf_port_model pb (.clk_i(clk), .sel_n_o(cb[3]), .wnr_o(cb[2]), .en_o(cb[1]),
		.mbs_o(cb[0]), .data_o(db), .data_i(qb));
	bcf_top bcf_top_inst (.SYS_CLK_I(clk), .NRST_I(nrst), .OFFSET_SELECT_HIGH_I(fs_hi),
		.OFFSET_SELECT_LOW_I(fs_lo), .PORT_A_SELECT_N_I(ca[3]), .PORT_A_WRITE_NOT_READ_I(ca[2]),
		.PORT_A_ENABLE_I(ca[1]), .PORT_A_MAILBOX_SELECT_I(ca[0]), .PORT_A_DATA_I(da),
		.PORT_A_DATA_O(qa), .PORT_A_DATA_OE_O(oea), .PORT_A_FULL_N_O(fa), .PORT_A_EMPTY_N_O(ea),
		.PORT_A_ALMOST_FULL_N_O(afa), .PORT_A_ALMOST_EMPTY_N_O(aea),
		.PORT_B_SELECT_N_I(cb[3]), .PORT_B_WRITE_NOT_READ_I(cb[2]),
		.PORT_B_ENABLE_I(cb[1]), .PORT_B_MAILBOX_SELECT_I(cb[0]), .PORT_B_DATA_I(db),
		.PORT_B_DATA_O(qb), .PORT_B_DATA_OE_O(oeb), .PORT_B_FULL_N_O(fb), .PORT_B_EMPTY_N_O(eb),
		.PORT_B_ALMOST_FULL_N_O(afb), .PORT_B_ALMOST_EMPTY_N_O(aeb),
		.MAILBOX_AB_FULL_N_O(m1), .MAILBOX_BA_FULL_N_O(m2));

	////////////////////////////////////////////////////////////////
	function automatic bcf_word_t rnd();
		lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
		return {lfsr[3:0], lfsr};
	endfunction
	task automatic end_sim();
		$display("checks %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic quiet(input int n);
		pb.drv(1'b1, 1'b1, 1'b0, 1'b0, '0);
		pa.idle(n);
	endtask
	// reset with offset selects, which flip once the release is past
	task automatic rst(input logic hi, lo);
		nrst = 1'b0;
		fs_hi = hi;
		fs_lo = lo;
		quiet(5);
		`CHK("reset flags", 10'h00f, {fa, fb, ea, eb, aea, aeb, afa, afb, m1, m2})
		nrst = 1'b1;
		quiet(3);
		`CHK("full flags", 2'h3, {fa, fb})
		fs_hi = ~hi;
		fs_lo = ~lo;
		ab_q.delete();
		ba_q.delete();
	endtask
	task automatic wr(input bit b, input int n);
		for (int i = 0; i < n; i++) begin
			w = rnd();
			if (b) begin
				if (ba_q.size() < `BCF_DEPTH) ba_q.push_back(w);
				pb.op(1'b1, 1'b0, w);
			end else begin
				if (ab_q.size() < `BCF_DEPTH) ab_q.push_back(w);
				pa.op(1'b1, 1'b0, w);
			end
		end
		quiet(4);
	endtask
	task automatic rd(input bit b, input int n);
		for (int i = 0; i < n; i++) begin
			if (b) begin
				pb.op(1'b0, 1'b0, '0);
				last = ab_q.pop_front();
				`CHK("b word", last, pb.seen)
			end else begin
				pa.op(1'b0, 1'b0, '0);
				last = ba_q.pop_front();
				`CHK("a word", last, pa.seen)
			end
		end
		quiet(4);
	endtask

	////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			fail_count++;
			end_sim();
		end
	end

	initial begin
		@(negedge clk);
		for (int k = 0; k < 4; k++) begin
			rst(k[1], k[0]);
			wr(1'b0, 4 * (k + 1));
			`CHK("ae at offset", 1'b0, aeb)
			wr(1'b0, 1);
			`CHK("ae above offset", 1'b1, aeb)
			rd(1'b1, 4 * (k + 1) + 1);
			`CHK("b empty", 1'b0, eb)
			pb.op(1'b0, 1'b0, '0);
			`CHK("b held", last, pb.seen)
			quiet(1);
		end
		$display("test offsets done");
		wr(1'b1, 5);
		rst(1'b0, 1'b0);
		wr(1'b1, `BCF_DEPTH + 2);
		`CHK("b full", 2'h0, {fb, afb})
		rd(1'b0, 30);
		rd(1'b0, 34);
		`CHK("a empty", 1'b0, ea)
		$display("test full and mid reset done");
		w = rnd();
		pa.op(1'b1, 1'b1, w);
		pa.drv(1'b1, 1'b1, 1'b0, 1'b0, '0);
		pb.drv(1'b0, 1'b0, 1'b0, 1'b1, '0);
		#1;
		`CHK("mail ab flag", 1'b0, m1)
		`CHK("mail ab word", w, qb)
		@(negedge clk);
		pb.op(1'b0, 1'b1, '0);
		`CHK("mail ab read", 1'b1, m1)
		last = rnd();
		pa.drv(1'b0, 1'b0, 1'b0, 1'b1, '0);
		pb.op(1'b1, 1'b1, last);
		`CHK("mail ba flag", 2'h2, {m1, m2})
		`CHK("mail ba word", last, qa)
		pb.drv(1'b1, 1'b1, 1'b0, 1'b0, '0);
		pa.op(1'b0, 1'b1, '0);
		`CHK("mail ba read", 1'b1, m2)
		pa.op(1'b1, 1'b1, rnd());
		rst(1'b0, 1'b0);
		$display("test mailbox done");
		for (int i = 0; i < 4; i++) begin
			pa.drv(i[1], i[0], 1'b0, 1'b0, '0);
			pb.drv(i[0], i[1], 1'b0, 1'b0, '0);
			@(negedge clk);
			`CHK("drive enables", {i == 0, i == 0}, {oea, oeb})
		end
		$display("test drive enables done");
		end_sim();
	end
endmodule
